/* File: tb/psc_host.sv */
// Host model: request pulse, serial bits and start-up clock
module psc_host (
  input  wire logic i_ref_clk,
  output logic      o_req_n,
  output logic      o_lclk,
  output logic      o_data,
  output logic      o_uclk
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {o_req_n, o_lclk, o_data, o_uclk} = 4'h8;
  task automatic ticks(input int n);
    repeat (n) @(posedge i_ref_clk);
    #2;
  endtask
  // Low for 600 ns, then 232 us of quiet, well past the status release
  // Toggles start from the idle level, request high
  task automatic request();
    o_req_n = ~o_req_n;
    ticks(30);
    o_req_n = ~o_req_n;
    ticks(11600);
  endtask
  // 160 ns load clock parked low between frames; data stays driven afterwards
  task automatic send(input logic [63:0] img, input int n);
    for (int i = 0; i < n; i++) begin
      o_data = img[i];
      ticks(4);
      o_lclk = ~o_lclk;
      ticks(4);
      o_lclk = ~o_lclk;
    end
  endtask
  // Start-up clock, 160 ns per period
  task automatic uclk(input int n);
    repeat (n) begin
      o_uclk = ~o_uclk;
      ticks(4);
      o_uclk = ~o_uclk;
      ticks(4);
    end
  endtask
endmodule // psc_host

/* File: tb/psc_loader_monitor.sv */
// Checker of the loader's pin timing, bound to the loader
module psc_loader_monitor #(parameter IMAGE_BITS = 32'd64) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_cfg_request_n,
  input wire logic i_serial_load_clock,
  input wire logic i_user_startup_clock,
  input wire logic i_use_user_clock,
  input wire logic o_status_oe,
  input wire logic o_done_oe,
  input wire logic o_user_mode,
  input wire logic o_user_io_tristate,
  input wire logic o_user_pullup_en
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  int   st, rel, cd, uc, nb;
  logic por_done, lc_q, uc_q;
  // Pulse, bit and start-up counters; the first status pulse is power-on and exempt
  always @(posedge i_ref_clk) begin
    lc_q <= i_serial_load_clock;
    uc_q <= i_user_startup_clock;
    if (!i_rstn) begin
      {st, rel, cd, uc, nb} <= '0;
      por_done <= 1'b0;
    end else begin
      st  <= o_status_oe ? st + 1 : 0;
      rel <= (o_status_oe && i_cfg_request_n) ? rel + 1 : 0;
      cd  <= o_done_oe ? 0 : cd + 1;
      uc  <= o_done_oe ? 0 : uc + int'(i_user_startup_clock && !uc_q);
      nb  <= o_status_oe ? 0 : nb + int'(i_serial_load_clock && !lc_q);
      if ($fell(o_status_oe)) por_done <= 1'b1;
    end
  end
  a_done_drop: assert property ($fell(i_cfg_request_n) |-> ##[1:25] o_done_oe)
    else $error("done not pulled low in time");
  a_status_drop: assert property ($fell(i_cfg_request_n) |-> ##[1:25] o_status_oe)
    else $error("status not pulled low in time");
  a_status_min: assert property ($fell(o_status_oe) && por_done |-> st >= 3500)
    else $error("status pulse too short");
  a_status_max: assert property (rel <= 11500)
    else $error("status held too long");
  a_done_bits: assert property ($fell(o_done_oe) |-> nb >= IMAGE_BITS)
    else $error("done released before image loaded");
  a_timer_start: assert property ($rose(o_user_mode) && !i_use_user_clock |->
    cd >= 15000 && cd <= 32500)
    else $error("timer start-up out of range");
  a_uclk_start: assert property ($rose(o_user_mode) && i_use_user_clock |-> uc >= 3187)
    else $error("start-up before enough user clocks");
  a_power_on: assert property ($rose(i_rstn) |-> (o_status_oe && o_done_oe) [*8])
    else $error("status or done released at power-on");
  a_user_lines: assert property (o_user_mode |-> !o_status_oe && !o_done_oe)
    else $error("line driven low in user mode");
  a_restart: assert property (o_user_mode && $fell(i_cfg_request_n) |-> ##[1:25] !o_user_mode)
    else $error("request did not leave user mode");
  a_pins_guard: assert property (!o_user_mode |-> o_user_io_tristate && o_user_pullup_en)
    else $error("user pins not guarded");
  c_timer: cover property ($rose(o_user_mode) && !i_use_user_clock);
  c_uclk: cover property ($rose(o_user_mode) && i_use_user_clock);
  c_pulse: cover property ($fell(o_status_oe) && por_done);
endmodule // psc_loader_monitor

bind psc_loader psc_loader_monitor #(.IMAGE_BITS(IMAGE_BITS)) psc_loader_monitor_i (.*);

/* File: tb/psc_loader_tb.sv */
// Bench of the loader: host model, word scoreboard and timing checks
module psc_loader_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, rstn, err, use_uc, rdy, stall;
  logic [7:0]  exp_q[$];
  int          error_cnt, n_tests, cnt;
  wire         req_n, lclk, sdat, uclk, st_oe, st_o, dn_oe, dn_o, um, tri_en, pu_en, wv;
  wire [7:0]   word;
  wire         st_line = st_oe ? st_o : 1'b1;  // Pulled up when released
  wire         dn_line = dn_oe ? dn_o : 1'b1;
  psc_host psc_host_i (.i_ref_clk(clk), .o_req_n(req_n), .o_lclk(lclk), .o_data(sdat),
    .o_uclk(uclk));
  psc_loader #(.IMAGE_BITS(32'd64), .POR_CYCLES(32'd20), .STATUS_CYC(32'd3600),
    .INIT_CYC(32'd15100)) psc_loader_i (.i_ref_clk(clk), .i_rstn(rstn),
    .i_cfg_request_n(req_n), .i_serial_load_clock(lclk), .i_serial_data(sdat),
    .i_user_startup_clock(uclk), .i_use_user_clock(use_uc), .i_error(err),
    .i_status_in(st_line), .i_done_in(dn_line), .o_status_oe(st_oe), .o_status_out(st_o),
    .o_done_oe(dn_oe), .o_done_out(dn_o), .o_user_mode(um), .o_user_io_tristate(tri_en),
    .o_user_pullup_en(pu_en), .o_word(word), .o_word_valid(wv), .i_word_ready(rdy));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Bounded wait on status (0), done (1) or user mode (2); n returns the cycles taken
  task automatic wait_for(input int sel, input logic val, input int lim, output int n);
    n = 0;
    while (((sel == 0) ? st_oe : (sel == 1) ? dn_oe : um) !== val) begin
      psc_host_i.ticks(1);
      n++;
      if (n > lim) begin
        chk(32'h0, 32'h1);
        tally_and_finish();
      end
    end
  endtask
  // Random image; words expected LSB first, first bit in bit 0
  task automatic load();
    logic [63:0] img;
    img = {$urandom, $urandom};
    for (int w = 0; w < 8; w++) exp_q.push_back(img[8*w +: 8]);
    psc_host_i.send(img, 64);
    wait_for(1, 1'b0, 100, cnt);
  endtask
  // Start-up in the mode that use_uc selects, then the user mode pin levels
  task automatic startup();
    if (use_uc) begin
      psc_host_i.ticks(40);
      psc_host_i.uclk(3180);
      chk({31'h0, um}, 32'h0);
      psc_host_i.uclk(20);
      wait_for(2, 1'b1, 50, cnt);
    end else begin
      wait_for(2, 1'b1, 32600, cnt);
      chk({31'h0, cnt >= 15000 && cnt <= 32500}, 32'h1);
    end
    chk({28'h0, st_oe, dn_oe, tri_en, pu_en}, 32'h0);
    chk(exp_q.size(), 32'h0);
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Scoreboard; the reader stalls fully while the buffer fills, then at random
  always @(posedge clk) begin
    if (rstn && wv === 1'b1 && rdy) begin
      if (exp_q.size() == 0) chk(32'h1, 32'h0);
      else chk({24'h0, word}, {24'h0, exp_q.pop_front()});
    end
    #2 rdy = stall ? 1'b0 : ($urandom % 2) == 1;
  end
  initial begin
    {rstn, err, use_uc, rdy, stall} = 5'h01;
    {error_cnt, n_tests} = '0;
    cnt = $urandom(63952);
    use_uc = ($urandom % 2) == 1; // First round's start-up mode; the second takes the other
    psc_host_i.ticks(8);
    rstn = 1'b1;
    psc_host_i.ticks(1);
    chk({27'h0, st_oe, dn_oe, um, tri_en, pu_en}, 32'h1B);
    // Error after one to seven bits: status pulse, then restart without a new request
    psc_host_i.request();
    chk({31'h0, st_line}, 32'h1);
    psc_host_i.send({$urandom, $urandom}, 1 + ($urandom % 7));
    err = 1'b1;
    wait_for(0, 1'b1, 20, cnt);
    err = 1'b0;
    wait_for(0, 1'b0, 11500, cnt);
    chk({31'h0, cnt >= 3500}, 32'h1);
    chk({31'h0, dn_oe}, 32'h1);
    psc_host_i.ticks(100);
    fork
      load();
      begin psc_host_i.ticks(300); stall = 1'b0; end
    join
    startup();
    // Restart from user mode, start-up in the other mode
    use_uc = ~use_uc;
    psc_host_i.request();
    chk({31'h0, um}, 32'h0);
    load();
    startup();
    tally_and_finish();
  end
endmodule // psc_loader_tb

/* File: verilog/psc_fifo.v */
// Intentionally empty: the word buffer module sits in the loader's own file

/* File: verilog/psc_loader.v */
// Passive serial configuration loader: reset handshake, bit loading, start-up
`include "psc_regs.vh"

module psc_loader #(
  parameter IMAGE_BITS  = 32'd64,
  parameter POR_CYCLES  = 32'd5000,
  parameter STATUS_CYC  = 32'd5000,
  parameter INIT_CYC    = 32'd20000,
  parameter WORD_W      = 8,
  parameter FIFO_DEPTH  = 4,
  parameter FIFO_AW     = 2
) (
  input  wire              i_ref_clk,
  input  wire              i_rstn,
  input  wire              i_cfg_request_n,
  input  wire              i_serial_load_clock,
  input  wire              i_serial_data,
  input  wire              i_user_startup_clock,
  input  wire              i_use_user_clock,
  input  wire              i_error,
  input  wire              i_status_in,
  input  wire              i_done_in,
  output reg               o_status_oe,
  output wire              o_status_out,
  output reg               o_done_oe,
  output wire              o_done_out,
  output reg               o_user_mode,
  output reg               o_user_io_tristate,
  output reg               o_user_pullup_en,
  output wire [WORD_W-1:0] o_word,
  output wire              o_word_valid,
  input  wire              i_word_ready
);
  // ----------------------------------------------------------------------------
  // Derived cycle counts
  // ----------------------------------------------------------------------------
  localparam [31:0] STAT_MIN_CYC = `PSC_T_STATUS_MIN_US * `PSC_CLK_MHZ;
  localparam [31:0] CD2UM_MIN    = `PSC_T_CD2UM_MIN_US * `PSC_CLK_MHZ;

  reg  [2:0]  state;
  reg  [2:0]  next_state;
  reg  [31:0] timer;
  reg  [31:0] bit_cnt;
  reg  [12:0] usr_cnt;
  reg  [2:0]  req_sync;
  reg  [2:0]  serial_load_clock_sync;
  reg  [1:0]  data_sync;
  reg  [2:0]  usr_sync;
  reg  [1:0]  err_sync;
  reg  [1:0]  stat_sync;
  reg  [1:0]  done_sync;
  reg  [WORD_W-1:0] shift;
  reg  [3:0]  shift_cnt;
  reg         word_push;
  reg  [WORD_W-1:0] word_data;
  wire        req_low;
  wire        req_fall;
  wire        serial_load_clock_rise;
  wire        usr_rise;
  wire        fifo_ready;
  wire        bit_take;

  // ----------------------------------------------------------------------------
  // Input synchronisers and edge detection
  // ----------------------------------------------------------------------------
  // Edges are taken between the second and third stages only
  always @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      req_sync  <= 3'h7;
      serial_load_clock_sync <= 3'h0;
      data_sync <= 2'h0;
      usr_sync  <= 3'h0;
      err_sync  <= 2'h0;
      stat_sync <= 2'h0;
      done_sync <= 2'h0;
    end else begin
      req_sync  <= {req_sync[1:0], i_cfg_request_n};
      serial_load_clock_sync <= {serial_load_clock_sync[1:0], i_serial_load_clock};
      data_sync <= {data_sync[0], i_serial_data};
      usr_sync  <= {usr_sync[1:0], i_user_startup_clock};
      err_sync  <= {err_sync[0], i_error};
      stat_sync <= {stat_sync[0], i_status_in};
      done_sync <= {done_sync[0], i_done_in};
    end
  end

  assign req_low   = ~req_sync[1];
  assign req_fall  = req_sync[2] & ~req_sync[1];
  assign serial_load_clock_rise = ~serial_load_clock_sync[2] & serial_load_clock_sync[1];
  assign usr_rise  = ~usr_sync[2] & usr_sync[1];

  // A bit is counted only when it is shifted too, so count and data never drift;
  // a status line held low from outside keeps the first bit out (extended reset)
  assign bit_take  = serial_load_clock_rise && (!word_push || fifo_ready) &&
                     ((state == `PSC_ST_LOAD) || (state == `PSC_ST_WAIT && stat_sync[1]));

  // ----------------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------------
  // Request low is checked last so it wins from every state but power-on reset
  always @* begin
    next_state = state;
    case (state)
      `PSC_ST_POR:
        if (timer >= POR_CYCLES) next_state = `PSC_ST_RESET;
      `PSC_ST_RESET:
        if (req_low) next_state = `PSC_ST_RESET;
        else if (timer >= STATUS_CYC && timer >= STAT_MIN_CYC)
          next_state = `PSC_ST_WAIT;
      `PSC_ST_WAIT:
        if (bit_take) next_state = `PSC_ST_LOAD;
      `PSC_ST_LOAD:
        if (err_sync[1]) next_state = `PSC_ST_ERROR;
        else if (bit_cnt >= IMAGE_BITS) next_state = `PSC_ST_INIT;
      `PSC_ST_INIT:
        if (i_use_user_clock) begin
          if (usr_cnt >= `PSC_USR_CYCLES + `PSC_USR_ARM_EDGES)
            next_state = `PSC_ST_USER;
        end else if (timer >= INIT_CYC && timer >= CD2UM_MIN) begin
          next_state = `PSC_ST_USER;
        end
      `PSC_ST_USER:
        next_state = `PSC_ST_USER;
      `PSC_ST_ERROR:
        if (timer >= STATUS_CYC && timer >= STAT_MIN_CYC) next_state = `PSC_ST_WAIT;
      default:
        next_state = `PSC_ST_POR;
    endcase
    if (state != `PSC_ST_POR && req_low)
      next_state = `PSC_ST_RESET;
  end

  // State register, timer and counters
  always @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      state   <= `PSC_ST_POR;
      timer   <= 32'h0;
      bit_cnt <= 32'h0;
      usr_cnt <= 13'h0;
    end else begin
      state <= next_state;
      // Start-up time runs only once the shared done line reads high
      if (next_state != state || (state == `PSC_ST_RESET && req_low) ||
          (state == `PSC_ST_INIT && !done_sync[1]))
        timer <= 32'h0;
      else
        timer <= timer + 32'h1;
      if (state != `PSC_ST_LOAD && next_state == `PSC_ST_LOAD)
        bit_cnt <= 32'h1;
      else if (state == `PSC_ST_LOAD && bit_take)
        bit_cnt <= bit_cnt + 32'h1;
      if (state != `PSC_ST_INIT)
        usr_cnt <= 13'h0;
      else if (usr_rise && done_sync[1] && usr_cnt != 13'h1FFF)
        usr_cnt <= usr_cnt + 13'h1;
    end
  end

  // ----------------------------------------------------------------------------
  // Bit assembly into words
  // ----------------------------------------------------------------------------
  // A bit arriving while a finished word waits on a full buffer is dropped; the host may pause its clock freely
  always @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      shift     <= {WORD_W{1'b0}};
      shift_cnt <= 4'h0;
      word_push <= 1'b0;
      word_data <= {WORD_W{1'b0}};
    end else begin
      if (word_push && fifo_ready)
        word_push <= 1'b0;
      if (next_state == `PSC_ST_RESET || next_state == `PSC_ST_ERROR) begin
        shift_cnt <= 4'h0;
      end else if (bit_take) begin
        shift <= {data_sync[1], shift[WORD_W-1:1]};
        if (shift_cnt == WORD_W[3:0] - 4'h1) begin
          shift_cnt <= 4'h0;
          word_data <= {data_sync[1], shift[WORD_W-1:1]};
          word_push <= 1'b1;
        end else begin
          shift_cnt <= shift_cnt + 4'h1;
        end
      end
    end
  end

  psc_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_data    (word_data),
    .i_valid   (word_push),
    .o_ready   (fifo_ready),
    .o_data    (o_word),
    .o_valid   (o_word_valid),
    .i_ready   (i_word_ready)
  );

  // ----------------------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------------------
  // Open-drain lines only ever drive low; release lets the pull-up win
  assign o_status_out = 1'b0;
  assign o_done_out   = 1'b0;

  always @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_status_oe        <= 1'b1;
      o_done_oe          <= 1'b1;
      o_user_mode        <= 1'b0;
      o_user_io_tristate <= 1'b1;
      o_user_pullup_en   <= 1'b1;
    end else begin
      o_status_oe <= (next_state == `PSC_ST_POR) || (next_state == `PSC_ST_RESET) ||
                     (next_state == `PSC_ST_ERROR);
      o_done_oe   <= (next_state != `PSC_ST_INIT) &&
                     (next_state != `PSC_ST_USER);
      o_user_mode        <= (next_state == `PSC_ST_USER);
      o_user_io_tristate <= (next_state != `PSC_ST_USER);
      o_user_pullup_en   <= (next_state != `PSC_ST_USER);
    end
  end
endmodule // psc_loader

// Small first-in first-out buffer with valid and ready on both sides
module psc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             i_ref_clk,
  input  wire             i_rstn,
  input  wire [WIDTH-1:0] i_data,
  input  wire             i_valid,
  output wire             o_ready,
  output wire [WIDTH-1:0] o_data,
  output wire             o_valid,
  input  wire             i_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;

  // ----------------------------------------------------------------------------
  // Handshake
  // ----------------------------------------------------------------------------
  assign o_ready = (count != DEPTH[AW:0]);
  assign o_valid = (count != {(AW+1){1'b0}});
  assign o_data  = mem[rd_ptr];
  assign push    = i_valid & o_ready;
  assign pop     = o_valid & i_ready;

  // Pointer and occupancy update
  always @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end

  // Storage needs no reset; words are only read once valid
  always @(posedge i_ref_clk) begin
    if (push)
      mem[wr_ptr] <= i_data;
  end
endmodule // psc_fifo

/* File: verilog/psc_regs.vh */
// Timing constants and state codes for the passive serial configuration loader
`ifndef PSC_REGS_VH
`define PSC_REGS_VH
// ----------------------------------------------------------------------------
// Clock rate and timings
// ----------------------------------------------------------------------------
`define PSC_CLK_MHZ          50
`define PSC_T_CF2ST0_NS      500
`define PSC_T_STATUS_MIN_US  70
`define PSC_T_STATUS_MAX_US  230
`define PSC_T_CD2UM_MIN_US   300
`define PSC_T_CD2UM_MAX_US   650
`define PSC_USR_CYCLES       3187
`define PSC_USR_ARM_EDGES    4
// ----------------------------------------------------------------------------
// State codes
// ----------------------------------------------------------------------------
`define PSC_ST_POR    3'h0
`define PSC_ST_RESET  3'h1
`define PSC_ST_WAIT   3'h2
`define PSC_ST_LOAD   3'h3
`define PSC_ST_INIT   3'h4
`define PSC_ST_USER   3'h5
`define PSC_ST_ERROR  3'h6
`endif
